// ===== src/rmw_params.svh
// What this block does
// RULE1 - indivisible flag stays asserted across every read and write part of a sequence
// RULE2 - no bus grant is given while an indivisible sequence runs
// RULE3 - read S0: flag on, address, function code, size valid, read_write high
// RULE4 - read S1: address strobe and data strobe both asserted
// RULE5 - read: ack by end of S2 continues, else wait states sampled each falling edge
// RULE6 - read data captured at end of S4 of every read part
// RULE7 - S5 drops strobes; reads repeat; address, direction, code held for write part
// RULE8 - responder holds data and ack until strobes negate, then releases promptly
// RULE9 - idle gap asserts nothing new, does the modify; write part skipped if unneeded
// RULE10 - read_write stays read until write S0; data bus undriven before write S2
// RULE11 - write S0 drives read_write low; address may change
// RULE12 - write: address strobe S1, data on all 16 lines S2, data strobe S3
// RULE13 - write: ack by end of S2 ends one clock later, else wait states
// RULE14 - responder latches selected byte lanes, then acknowledges once stored
// RULE15 - write S5 drops strobes, holds address, data, direction, code; writes repeat
// RULE16 - special space (code 7) cycle type carried on address bits 19 to 16
// RULE17 - software breakpoint: word read type 0, number on bits 4..2, bit 1 clear
// RULE18 - soft breakpoint error gives illegal instruction, ack returns word (two byte reads); code splits into byte reads only on an 8-bit ack in S2
// RULE19 - hardware breakpoint: type 0 read, bits 4..2 ones, bit 1 set; error gives exception
// RULE20 - debug hardware holds breakpoint request until its acknowledge cycle appears
// RULE21 - low-power stop: waits for bus, type 3 write of mask level, acked internally
// RULE22 - halt asserted during the broadcast delays low-power entry
// RULE23 - register block 4 Kbytes, relocatable on 4K, base reached only at one special address
`ifndef RMW_PARAMS_SVH
`define RMW_PARAMS_SVH
`define RMW_FC_CPU 4'h7
`define RMW_TYPE_LSB 16
`define RMW_TYPE_BREAKPOINT_REQUEST 4'h0
`define RMW_TYPE_LOW_POWER_STOP 4'h3
`define RMW_TYPE_MBAR 4'h3
`define RMW_MBAR_ADDR 32'h0003FF00
`define RMW_BLOCK_BITS 12
`define RMW_HW_BREAKPOINT_REQUEST_NUM 3'h7
`define RMW_SIZE_BYTE 2'h1
`define RMW_SIZE_WORD 2'h2
`define RMW_ACK_PORT8 2'h2
`define RMW_STEP_WORD 32'h00000002
`define RMW_STEP_BYTE 32'h00000001
`define RMW_CPU_SPACE_BASE 32'h00000000
`endif

// ===== src/rmw_pkg.sv
package rmw_pkg;
	typedef enum logic [2:0] {
		RMW_KIND_RMW,
		RMW_KIND_SWBKPT,
		RMW_KIND_LOW_POWER_STOP,
		RMW_KIND_MBAR_WR,
		RMW_KIND_MBAR_RD,
		RMW_KIND_HWBKPT
	} rmw_kind_t;
	typedef enum logic [3:0] {
		RMW_ST_IDLE,
		RMW_ST_S0,
		RMW_ST_S1,
		RMW_ST_S2,
		RMW_ST_SW,
		RMW_ST_S3,
		RMW_ST_S4,
		RMW_ST_S5,
		RMW_ST_GAP,
		RMW_ST_HALTW
	} rmw_state_t;
endpackage

// ===== src/rmw_term_if.sv
`timescale 1ns/100ps
interface rmw_term_if;
	logic sample;
	logic internal_ack;
	logic clear;
	logic hit;
	logic bus_error_in;
	logic port8;
	logic halt_seen;
	modport seq (output sample, output internal_ack, output clear, input hit, input bus_error_in, input port8,
		input halt_seen);
	modport term (input sample, input internal_ack, input clear, output hit, output bus_error_in, output port8,
		output halt_seen);
endinterface

// ===== src/rmw_term.sv
`timescale 1ns/100ps
`include "rmw_params.svh"
module rmw_term
	import rmw_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic [1:0] transfer_ack_n_in,
	input wire logic bus_error_n_in,
	input wire logic halt_n_in,
	rmw_term_if.term t
);
	wire ack_any = ~&transfer_ack_n_in;
	wire bus_error_in_now = ~bus_error_n_in;
	logic halt_q;
	assign t.hit = t.sample & (ack_any | t.internal_ack | bus_error_in_now);
	assign t.bus_error_in = t.sample & bus_error_in_now;
	assign t.port8 = ~t.internal_ack & (transfer_ack_n_in == `RMW_ACK_PORT8);
	assign t.halt_seen = halt_q | ~halt_n_in;
	// halt seen at any time in a cycle is remembered; a new halt wins over the clear
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			halt_q <= 1'b0;
		end else if (ce_in) begin
			halt_q <= ~halt_n_in | (halt_q & ~t.clear);
		end
	end
endmodule

// ===== src/rmw_seq.sv
`timescale 1ns/100ps
`include "rmw_params.svh"
module rmw_seq
	import rmw_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire rmw_kind_t cmd_kind_in,
	input wire logic [31:0] cmd_addr_in,
	input wire logic [3:0] cmd_fc_in,
	input wire logic [1:0] cmd_size_in,
	input wire logic cmd_two_in,
	input wire logic [2:0] cmd_breakpoint_request_num_in,
	input wire logic [2:0] interrupt_mask_level_in,
	input wire logic [31:0] cmd_data_in,
	output logic rd_valid_out,
	input wire logic mod_valid_in,
	input wire logic mod_write_in,
	input wire logic mod_two_in,
	input wire logic [31:0] mod_addr_in,
	input wire logic [31:0] mod_data_in,
	output logic done_out,
	output logic [31:0] result_out,
	output logic bus_error_out,
	output logic illegal_instr_out,
	output logic hw_breakpoint_request_exc_out,
	output logic breakpoint_request_word_valid_out,
	output logic low_power_stop_out,
	input wire logic bgnd_mode_in,
	input wire logic breakpoint_request_n_in,
	input wire logic bus_request_n_in,
	output logic bus_grant_n_out,
	input wire logic [31:0] probe_addr_in,
	output logic regblock_hit_out,
	output logic [31:0] addr_out,
	output logic [3:0] function_code_out,
	output logic [1:0] transfer_size_out,
	output logic read_write_out,
	output logic address_strobe_n_out,
	output logic data_strobe_n_out,
	output logic indivisible_cycle_flag_n_out,
	output logic [15:0] data_out,
	output logic data_oe_out,
	input wire logic [15:0] data_in,
	input wire logic [1:0] transfer_ack_n_in,
	input wire logic bus_error_n_in,
	input wire logic halt_n_in
);
	rmw_term_if tif();
	rmw_term u_term (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.transfer_ack_n_in(transfer_ack_n_in),
		.bus_error_n_in(bus_error_n_in),
		.halt_n_in(halt_n_in),
		.t(tif.term)
	);

	rmw_state_t state_q, state_d;
	rmw_kind_t kind_q;
	logic [31:0] addr_q, wdata_q, rdata_q, mbar_q;
	logic [3:0] fc_q;
	logic [1:0] size_q;
	logic rw_q, rmc_q, two_q, second_q, wodd_q, err_q, p8_q, bg_q, hit_q;
	logic [2:0] nout_q;

	wire writing = ~rw_q;
	wire idle = (state_q == RMW_ST_IDLE);
	wire hw_req = ~breakpoint_request_n_in & ~bgnd_mode_in;
	wire start_hw = idle & ~bg_q & hw_req;
	wire start_cmd = idle & ~bg_q & ~hw_req & cmd_valid_in;
	wire mbar_kind = (cmd_kind_in == RMW_KIND_MBAR_WR) | (cmd_kind_in == RMW_KIND_MBAR_RD);
	// base register only answers in cpu space at its one fixed address
	wire mbar_ok = (cmd_fc_in == `RMW_FC_CPU) & (cmd_addr_in == `RMW_MBAR_ADDR); // [RULE23]
	wire bus_start = start_hw | (start_cmd & ~mbar_kind);
	wire end_of_part = (state_q == RMW_ST_S5);
	wire more_parts = ~err_q & two_q & ~second_q;
	wire lp_kind = (kind_q == RMW_KIND_LOW_POWER_STOP);
	wire gap_go = (state_q == RMW_ST_GAP) & mod_valid_in;
	wire [31:0] step = (size_q == `RMW_SIZE_BYTE) ? `RMW_STEP_BYTE : `RMW_STEP_WORD;
	// cpu-space address: type on 19..16, breakpoint number on 4..2, flag on bit 1
	wire [31:0] sw_addr = {12'h000, `RMW_TYPE_BREAKPOINT_REQUEST, 11'h000, cmd_breakpoint_request_num_in, 1'b0, 1'b0}; // [RULE16] [RULE17]
	wire [31:0] hw_addr = {12'h000, `RMW_TYPE_BREAKPOINT_REQUEST, 11'h000, `RMW_HW_BREAKPOINT_REQUEST_NUM, 1'b1, 1'b0}; // [RULE19]
	wire [31:0] lp_addr = {12'h000, `RMW_TYPE_LOW_POWER_STOP, 16'h0000}; // [RULE16] [RULE21]
	wire [31:0] blk_mask = ~((32'h00000001 << `RMW_BLOCK_BITS) - 32'h00000001);

	assign cmd_ready_out = idle & ~bg_q & ~hw_req;
	assign tif.sample = (state_q == RMW_ST_S2) | ((state_q == RMW_ST_SW) & wodd_q); // [RULE5] [RULE13]
	assign tif.internal_ack = lp_kind; // [RULE21]
	// stored halt dropped in the stop wait, so after its first cycle only a halt held in this or the previous cycle keeps it waiting
	assign tif.clear = idle | (state_q == RMW_ST_HALTW); // [RULE22]
	assign addr_out = addr_q;
	assign function_code_out = fc_q;
	assign transfer_size_out = size_q;
	assign read_write_out = rw_q;
	assign indivisible_cycle_flag_n_out = ~rmc_q;
	assign bus_grant_n_out = ~bg_q;
	assign data_out = wdata_q[15:0];
	assign regblock_hit_out = hit_q;

	// strobes follow the state register
	wire strobe_span = (state_q == RMW_ST_S2) | (state_q == RMW_ST_SW) | (state_q == RMW_ST_S3)
		| (state_q == RMW_ST_S4);
	assign address_strobe_n_out = ~((state_q == RMW_ST_S1) | strobe_span); // [RULE4] [RULE12]
	assign data_strobe_n_out = ~(writing ? ((state_q == RMW_ST_S3) | (state_q == RMW_ST_S4)) // [RULE12]
		: ((state_q == RMW_ST_S1) | strobe_span)); // [RULE4] [RULE7]
	assign data_oe_out = writing & ~idle & (state_q != RMW_ST_S0) & (state_q != RMW_ST_S1)
		& (state_q != RMW_ST_GAP) & (state_q != RMW_ST_HALTW); // [RULE10] [RULE12] [RULE15]

	always_comb begin
		state_d = state_q;
		case (state_q)
			RMW_ST_IDLE: begin
				if (bus_start) begin
					state_d = RMW_ST_S0;
				end
			end
			RMW_ST_S0: state_d = RMW_ST_S1;
			RMW_ST_S1: state_d = RMW_ST_S2;
			RMW_ST_S2: state_d = tif.hit ? RMW_ST_S3 : RMW_ST_SW; // [RULE5] [RULE13]
			RMW_ST_SW: state_d = tif.hit ? RMW_ST_S3 : RMW_ST_SW;
			RMW_ST_S3: state_d = RMW_ST_S4;
			RMW_ST_S4: state_d = RMW_ST_S5;
			RMW_ST_S5: begin
				if (more_parts) begin
					state_d = RMW_ST_S0; // [RULE7] [RULE15]
				end else if (lp_kind) begin
					state_d = RMW_ST_HALTW;
				end else if (kind_q == RMW_KIND_RMW && !writing && !err_q) begin
					state_d = RMW_ST_GAP; // [RULE9]
				end else begin
					state_d = RMW_ST_IDLE;
				end
			end
			RMW_ST_GAP: begin
				if (mod_valid_in) begin
					state_d = mod_write_in ? RMW_ST_S0 : RMW_ST_IDLE; // [RULE9]
				end
			end
			RMW_ST_HALTW: state_d = tif.halt_seen ? RMW_ST_HALTW : RMW_ST_IDLE; // [RULE22]
			default: state_d = RMW_ST_IDLE;
		endcase
	end

	wire last_end = end_of_part & ~more_parts;
	wire finish = (last_end & ~lp_kind & ~(kind_q == RMW_KIND_RMW & ~writing & ~err_q))
		| (gap_go & ~mod_write_in) | ((state_q == RMW_ST_HALTW) & ~tif.halt_seen);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_q <= RMW_ST_IDLE;
			wodd_q <= 1'b0;
		end else if (ce_in) begin
			state_q <= state_d;
			wodd_q <= (state_q == RMW_ST_SW) ? ~wodd_q : 1'b0;
		end
	end

	// address, code, direction and write data registers
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			addr_q <= 32'h00000000;
			fc_q <= 4'h0;
			size_q <= `RMW_SIZE_WORD;
			rw_q <= 1'b1;
			wdata_q <= 32'h00000000;
			kind_q <= RMW_KIND_RMW;
			two_q <= 1'b0;
			second_q <= 1'b0;
		end else if (ce_in) begin
			if (start_hw) begin
				kind_q <= RMW_KIND_HWBKPT;
				addr_q <= hw_addr;
				fc_q <= `RMW_FC_CPU;
				size_q <= `RMW_SIZE_WORD;
				rw_q <= 1'b1; // [RULE19]
				two_q <= 1'b0;
				second_q <= 1'b0;
			end else if (start_cmd && !mbar_kind) begin
				kind_q <= cmd_kind_in;
				second_q <= 1'b0;
				case (cmd_kind_in)
					RMW_KIND_SWBKPT: begin
						addr_q <= sw_addr;
						fc_q <= `RMW_FC_CPU;
						size_q <= `RMW_SIZE_WORD;
						rw_q <= 1'b1;
						two_q <= 1'b0;
					end
					RMW_KIND_LOW_POWER_STOP: begin
						addr_q <= lp_addr;
						fc_q <= `RMW_FC_CPU;
						size_q <= `RMW_SIZE_WORD;
						rw_q <= 1'b0;
						wdata_q <= {29'h00000000, interrupt_mask_level_in}; // [RULE21]
						two_q <= 1'b0;
					end
					default: begin
						addr_q <= cmd_addr_in;
						fc_q <= cmd_fc_in;
						size_q <= cmd_size_in;
						rw_q <= 1'b1; // [RULE3]
						wdata_q <= cmd_data_in;
						two_q <= cmd_two_in;
					end
				endcase
			end else if (gap_go && mod_write_in) begin
				addr_q <= mod_addr_in; // [RULE11]
				// two writes: upper half goes out first, so it sits in the low half
				wdata_q <= mod_two_in ? {mod_data_in[15:0], mod_data_in[31:16]} : mod_data_in; // [RULE15]
				rw_q <= 1'b0; // [RULE10] [RULE11]
				two_q <= mod_two_in;
				second_q <= 1'b0;
			end else if (end_of_part && more_parts) begin
				addr_q <= addr_q + step;
				second_q <= 1'b1;
				if (writing) begin
					wdata_q <= {16'h0000, wdata_q[31:16]}; // [RULE15]
				end
			end else if (state_q == RMW_ST_S2 && kind_q == RMW_KIND_SWBKPT && tif.hit && tif.port8
				&& !second_q) begin
				two_q <= 1'b1; // [RULE18]
				size_q <= `RMW_SIZE_BYTE;
			end
		end
	end

	// read capture, error and port size tracking
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
			p8_q <= 1'b0;
		end else if (ce_in) begin
			if (bus_start) begin
				err_q <= 1'b0;
				p8_q <= 1'b0;
			end else if (tif.hit) begin
				err_q <= tif.bus_error_in;
				p8_q <= tif.port8;
			end
			if (state_q == RMW_ST_S4 && !writing) begin
				rdata_q <= p8_q ? {rdata_q[23:0], data_in[15:8]} : {rdata_q[15:0], data_in}; // [RULE6] [RULE18]
			end
		end
	end

	// indivisible flag, grant and register block base
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rmc_q <= 1'b0;
			bg_q <= 1'b0;
			mbar_q <= 32'h00000000;
			hit_q <= 1'b0;
		end else if (ce_in) begin
			if (start_cmd && cmd_kind_in == RMW_KIND_RMW) begin
				rmc_q <= 1'b1; // [RULE1] [RULE3]
			end else if (finish) begin
				rmc_q <= 1'b0;
			end
			bg_q <= idle & ~bus_start & ~bus_request_n_in & ~rmc_q & (bg_q | ~cmd_valid_in); // [RULE2]
			if (start_cmd && cmd_kind_in == RMW_KIND_MBAR_WR && mbar_ok) begin
				mbar_q <= cmd_data_in & blk_mask; // [RULE23]
			end
			hit_q <= ((probe_addr_in & blk_mask) == mbar_q);
		end
	end

	// completion pulses
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			done_out <= 1'b0;
			result_out <= 32'h00000000;
			bus_error_out <= 1'b0;
			illegal_instr_out <= 1'b0;
			hw_breakpoint_request_exc_out <= 1'b0;
			breakpoint_request_word_valid_out <= 1'b0;
			low_power_stop_out <= 1'b0;
			rd_valid_out <= 1'b0;
		end else if (ce_in) begin
			done_out <= finish | (start_cmd & mbar_kind);
			bus_error_out <= (finish & err_q) | (start_cmd & mbar_kind & ~mbar_ok); // [RULE23]
			illegal_instr_out <= last_end & err_q & (kind_q == RMW_KIND_SWBKPT); // [RULE18]
			hw_breakpoint_request_exc_out <= last_end & err_q & (kind_q == RMW_KIND_HWBKPT); // [RULE19]
			breakpoint_request_word_valid_out <= last_end & ~err_q & (kind_q == RMW_KIND_SWBKPT); // [RULE18]
			low_power_stop_out <= (state_q == RMW_ST_HALTW) & ~tif.halt_seen; // [RULE22]
			rd_valid_out <= last_end & (kind_q == RMW_KIND_RMW) & ~writing & ~err_q;
			if (start_cmd && cmd_kind_in == RMW_KIND_MBAR_RD) begin
				result_out <= mbar_ok ? mbar_q : 32'h00000000; // [RULE23]
			end else if (last_end && !writing) begin
				result_out <= (kind_q == RMW_KIND_SWBKPT && p8_q) ? {16'h0000, rdata_q[15:0]} : rdata_q;
			end
		end
	end

	property p_rmc_hold;
		@(posedge clk_in) disable iff (sys_rst_in)
		(state_q == RMW_ST_GAP) |-> rmc_q && rw_q;
	endproperty
	a_rmc_hold: assert property (p_rmc_hold) else $error("flag or direction dropped in gap"); // [RULE1] [RULE10]

	property p_no_grant;
		@(posedge clk_in) disable iff (sys_rst_in)
		rmc_q |-> bus_grant_n_out;
	endproperty
	a_no_grant: assert property (p_no_grant) else $error("grant during indivisible sequence"); // [RULE2]

	property p_read_s1;
		@(posedge clk_in) disable iff (sys_rst_in)
		ce_in && state_q == RMW_ST_S0 && rw_q |=> !address_strobe_n_out && !data_strobe_n_out;
	endproperty
	a_read_s1: assert property (p_read_s1) else $error("read strobes not asserted in S1"); // [RULE4]

	property p_s0_idle_strobes;
		@(posedge clk_in) disable iff (sys_rst_in)
		(state_q == RMW_ST_S0 || state_q == RMW_ST_S5) |-> address_strobe_n_out && data_strobe_n_out;
	endproperty
	a_s0_idle_strobes: assert property (p_s0_idle_strobes) else $error("strobe asserted in S0 or S5"); // [RULE7]

	property p_wdata_late;
		@(posedge clk_in) disable iff (sys_rst_in)
		(state_q == RMW_ST_S1 || state_q == RMW_ST_GAP) |-> !data_oe_out;
	endproperty
	a_wdata_late: assert property (p_wdata_late) else $error("data bus driven before S2"); // [RULE10]

	property p_write_ds;
		@(posedge clk_in) disable iff (sys_rst_in)
		ce_in && state_q == RMW_ST_S1 && !rw_q |=> data_strobe_n_out && data_oe_out && !address_strobe_n_out;
	endproperty
	a_write_ds: assert property (p_write_ds) else $error("write S2 signalling wrong"); // [RULE12]

	property p_fast_end;
		@(posedge clk_in) disable iff (sys_rst_in)
		ce_in && tif.hit && state_q == RMW_ST_S2 ##1 ce_in ##1 ce_in |=> state_q == RMW_ST_S5;
	endproperty
	a_fast_end: assert property (p_fast_end) else $error("cycle did not end after ack"); // [RULE5] [RULE13]

	property p_lp_space;
		@(posedge clk_in) disable iff (sys_rst_in)
		kind_q == RMW_KIND_LOW_POWER_STOP && state_q == RMW_ST_S1 |-> fc_q == `RMW_FC_CPU
			&& addr_q[19:16] == `RMW_TYPE_LOW_POWER_STOP && !rw_q && wdata_q[31:3] == 29'h00000000;
	endproperty
	a_lp_space: assert property (p_lp_space) else $error("stop broadcast encoding wrong"); // [RULE21]

	property p_hw_addr;
		@(posedge clk_in) disable iff (sys_rst_in)
		kind_q == RMW_KIND_HWBKPT && state_q == RMW_ST_S1 |-> addr_q[4:1] == 4'hF && addr_q[19:16] == 4'h0;
	endproperty
	a_hw_addr: assert property (p_hw_addr) else $error("hardware breakpoint address wrong"); // [RULE19]

	property p_halt_delay;
		@(posedge clk_in) disable iff (sys_rst_in)
		state_q == RMW_ST_HALTW && tif.halt_seen |=> !low_power_stop_out;
	endproperty
	a_halt_delay: assert property (p_halt_delay) else $error("stop entered under halt"); // [RULE22]
endmodule

// ===== testbench/rmw_resp_model.sv
`timescale 1ns/100ps
module rmw_resp_model (
	input wire logic clk_in,
	input wire logic as_n_in,
	input wire logic rw_in,
	input wire logic [31:0] addr_in,
	input wire logic [3:0] waits_in,
	input wire logic ack_en_in,
	input wire logic bus_error_in_en_in,
	input wire logic port8_in,
	output logic [1:0] ack_n_out,
	output logic bus_error_in_n_out,
	output logic [15:0] data_out
);
	logic [3:0] cnt_q = 4'h0;
	logic [15:0] last_q = 16'h0000;
	logic sel;
	logic [15:0] word;
	assign sel = !as_n_in && (cnt_q >= waits_in);
	// ack held while strobe low, dropped as soon as it negates
	assign ack_n_out = (sel && ack_en_in && !bus_error_in_en_in) ? (port8_in ? 2'h2 : 2'h1) : 2'h3;
	assign bus_error_in_n_out = !(sel && bus_error_in_en_in);
	assign word = port8_in ? {addr_in[7:0] ^ 8'hC3, ~last_q[7:0]} : addr_in[15:0] ^ 16'h5A3C;
	// released bus shows the inverse of the last driven value
	assign data_out = (!as_n_in && rw_in) ? word : ~last_q;
	always_ff @(posedge clk_in) begin
		cnt_q <= as_n_in ? 4'h0 : cnt_q + 4'h1;
		if (!as_n_in && rw_in)
			last_q <= word;
	end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench
	import rmw_pkg::*;
;
	logic clk = 0, rst = 1, cmd_valid = 0, two = 0, mod_valid = 1, mod_write = 1, mod_two = 0;
	logic bgnd = 0, bp_n = 1, br_n = 1, halt_n = 1, ack_en = 1, bus_error_in_en = 0, port8 = 0;
	rmw_kind_t kind = RMW_KIND_RMW;
	logic [31:0] caddr = 0, cdata = 0, maddr = 0, mdata = 0, probe = 0, result, addr;
	logic [3:0] fc = 4'h5, waits = 4'h0, fco;
	logic [2:0] bnum = 0, mask = 0;
	logic [1:0] tsz, ack_n;
	logic [15:0] dout, din;
	logic ready, rdv, done, bus_error_in_o, ill, hwx, bwv, lps, grant_n, hit, rw, as_n, ds_n, flag_n, doe, bus_error_in_n;
	int err_count = 0, n_tests = 0, low_n = 0;
	logic [31:0] q_addr[$];
	logic [3:0] q_fc[$];
	logic q_rw[$];
	logic [15:0] q_wd[$];
	int q_len[$];
	logic as_p = 1, ds_p = 1, in_seq = 0;
	logic [5:0] stk = 0;
	rmw_seq uut (.clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1), .cmd_valid_in(cmd_valid), .cmd_ready_out(ready),
		.cmd_kind_in(kind), .cmd_addr_in(caddr), .cmd_fc_in(fc), .cmd_size_in(2'h2), .cmd_two_in(two),
		.cmd_breakpoint_request_num_in(bnum), .interrupt_mask_level_in(mask), .cmd_data_in(cdata), .rd_valid_out(rdv),
		.mod_valid_in(mod_valid), .mod_write_in(mod_write), .mod_two_in(mod_two), .mod_addr_in(maddr),
		.mod_data_in(mdata), .done_out(done), .result_out(result), .bus_error_out(bus_error_in_o), .illegal_instr_out(ill),
		.hw_breakpoint_request_exc_out(hwx), .breakpoint_request_word_valid_out(bwv), .low_power_stop_out(lps), .bgnd_mode_in(bgnd),
		.breakpoint_request_n_in(bp_n), .bus_request_n_in(br_n), .bus_grant_n_out(grant_n), .probe_addr_in(probe),
		.regblock_hit_out(hit), .addr_out(addr), .function_code_out(fco), .transfer_size_out(tsz),
		.read_write_out(rw), .address_strobe_n_out(as_n), .data_strobe_n_out(ds_n),
		.indivisible_cycle_flag_n_out(flag_n), .data_out(dout), .data_oe_out(doe), .data_in(din),
		.transfer_ack_n_in(ack_n), .bus_error_n_in(bus_error_in_n), .halt_n_in(halt_n));
	rmw_resp_model far (.clk_in(clk), .as_n_in(as_n), .rw_in(rw), .addr_in(addr), .waits_in(waits),
		.ack_en_in(ack_en), .bus_error_in_en_in(bus_error_in_en), .port8_in(port8), .ack_n_out(ack_n), .bus_error_in_n_out(bus_error_in_n),
		.data_out(din));
	always #12.5 clk = ~clk;
	// bus monitor: records each part at its strobe edges
	always @(negedge clk) begin
		if (!as_n && as_p) begin
			q_addr.push_back(addr);
			q_fc.push_back(fco);
			q_rw.push_back(rw);
			`CHK("size_at_s1", (port8 && q_addr.size() > 1) ? 2'h1 : 2'h2, tsz)
			`CHK("ds_at_s1", !rw, ds_n)
			`CHK("oe_at_s1", 1'b0, doe)
			if (kind == RMW_KIND_RMW)
				in_seq = 1;
		end
		if (!ds_n && ds_p && !rw) begin
			q_wd.push_back(dout);
			`CHK("oe_at_ds", 1'b1, doe)
		end
		if (doe)
			`CHK("rw_while_oe", 1'b0, rw)
		if (as_n && !as_p)
			q_len.push_back(low_n);
		low_n = as_n ? 0 : low_n + 1;
		if (in_seq && !done)
			`CHK("flag_held", 1'b0, flag_n)
		if (!flag_n)
			`CHK("no_grant", 1'b1, grant_n)
		if (done)
			in_seq = 0;
		stk = stk | {rdv, bus_error_in_o, ill, hwx, bwv, lps};
		as_p = as_n;
		ds_p = ds_n;
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task clr;
		q_addr.delete();
		q_fc.delete();
		q_rw.delete();
		q_wd.delete();
		q_len.delete();
		stk = 0;
	endtask
	task issue(input rmw_kind_t k);
		int i;
		i = 0;
		clr();
		tick(1);
		kind = k;
		cmd_valid = 1;
		do @(negedge clk); while (ready !== 1'b1 && ++i < 100);
		tick(1);
		cmd_valid = 0;
	endtask
	task wait_done;
		int i;
		i = 0;
		do @(negedge clk); while (done !== 1'b1 && ++i < 300);
		`CHK("done", 1'b1, done)
		tick(1);
	endtask
	task t_rmw1;
		caddr = 32'h00001234;
		maddr = 32'h00001234;
		mdata = 32'h0000BEEF;
		issue(RMW_KIND_RMW);
		wait_done();
		`CHK("parts", 2, q_addr.size())
		`CHK("rd_addr", caddr, q_addr[0])
		`CHK("rd_rw", 1'b1, q_rw[0])
		`CHK("rd_data", 16'h1234 ^ 16'h5A3C, result[15:0])
		`CHK("rd_valid", 1'b1, stk[5])
		`CHK("wr_rw", 1'b0, q_rw[1])
		`CHK("wr_data", 16'hBEEF, q_wd[0])
		`CHK("rd_len", 4, q_len[0])
		`CHK("wr_len", 4, q_len[1])
		`CHK("flag_end", 1'b1, flag_n)
	endtask
	task t_rmw2;
		int i;
		caddr = 32'h00002000;
		maddr = 32'h00003000;
		mdata = 32'h11112222;
		two = 1;
		mod_two = 1;
		waits = 4'h3;
		issue(RMW_KIND_RMW);
		br_n = 0;
		wait_done();
		`CHK("parts", 4, q_addr.size())
		`CHK("rd2_addr", caddr + 32'h2, q_addr[1])
		`CHK("rd_data", {16'h2000 ^ 16'h5A3C, 16'h2002 ^ 16'h5A3C}, result)
		`CHK("rd_wait_len", 6, q_len[0])
		`CHK("wr_wait_len", 6, q_len[2])
		`CHK("wr_addr", maddr, q_addr[2])
		`CHK("wr1", 16'h1111, q_wd[0])
		`CHK("wr2", 16'h2222, q_wd[1])
		i = 0;
		do @(negedge clk); while (grant_n !== 1'b0 && ++i < 10);
		`CHK("grant", 1'b0, grant_n)
		`CHK("ready_granted", 1'b0, ready)
		tick(1);
		br_n = 1;
		two = 0;
		mod_two = 0;
		waits = 4'h0;
		tick(3);
		`CHK("grant_off", 1'b1, grant_n)
	endtask
	task t_rmw_skip;
		mod_write = 0;
		issue(RMW_KIND_RMW);
		wait_done();
		`CHK("no_write", 1, q_addr.size())
		mod_write = 1;
		bus_error_in_en = 1;
		issue(RMW_KIND_RMW);
		wait_done();
		`CHK("bus_error_in_parts", 1, q_addr.size())
		`CHK("bus_error_in_out", 1'b1, stk[4])
		bus_error_in_en = 0;
	endtask
	task t_swbp;
		logic [15:0] w;
		bnum = 3'h5;
		for (int p = 0; p < 2; p++) begin
			port8 = p[0];
			issue(RMW_KIND_SWBKPT);
			wait_done();
			w = port8 ? {q_addr[0][7:0] ^ 8'hC3, q_addr[1][7:0] ^ 8'hC3} : q_addr[0][15:0] ^ 16'h5A3C;
			`CHK("bp_fc", 4'h7, q_fc[0])
			`CHK("bp_type", 4'h0, q_addr[0][19:16])
			`CHK("bp_num", bnum, q_addr[0][4:2])
			`CHK("bp_tbit", 1'b0, q_addr[0][1])
			`CHK("bp_reads", p + 1, q_addr.size())
			`CHK("bp_word", w, result[15:0])
			`CHK("bp_valid", 1'b1, stk[1])
		end
		port8 = 0;
		bus_error_in_en = 1;
		issue(RMW_KIND_SWBKPT);
		wait_done();
		`CHK("illegal", 1'b1, stk[3])
		bus_error_in_en = 0;
	endtask
	task t_hwbp(input logic err);
		int i;
		clr();
		bus_error_in_en = err;
		bp_n = 0;
		i = 0;
		do @(negedge clk); while (q_addr.size() == 0 && ++i < 50);
		tick(1);
		bp_n = 1;
		wait_done();
		`CHK("hb_fc", 4'h7, q_fc[0])
		`CHK("hb_num", 3'h7, q_addr[0][4:2])
		`CHK("hb_tbit", 1'b1, q_addr[0][1])
		`CHK("hb_exc", err, stk[2])
		bus_error_in_en = 0;
	endtask
	task t_hw_bgnd;
		clr();
		bgnd = 1;
		bp_n = 0;
		tick(20);
		`CHK("bgnd_quiet", 0, q_addr.size())
		bp_n = 1;
		bgnd = 0;
		tick(2);
	endtask
	task t_lps;
		ack_en = 0;
		halt_n = 0;
		mask = 3'h5;
		issue(RMW_KIND_LOW_POWER_STOP);
		tick(40);
		`CHK("lps_held", 1'b0, stk[0])
		halt_n = 1;
		wait_done();
		`CHK("lps_entry", 1'b1, stk[0])
		`CHK("lps_type", 4'h3, q_addr[0][19:16])
		`CHK("lps_fc", 4'h7, q_fc[0])
		`CHK("lps_rw", 1'b0, q_rw[0])
		`CHK("lps_mask", mask, q_wd[0][2:0])
		ack_en = 1;
	endtask
	task t_mbar;
		logic [31:0] pr [4] = '{32'h12345000, 32'h12345FFF, 32'h12346000, 32'h12344FFF};
		caddr = 32'h0003FF00;
		fc = 4'h7;
		cdata = 32'h12345ABC;
		issue(RMW_KIND_MBAR_WR);
		wait_done();
		issue(RMW_KIND_MBAR_RD);
		wait_done();
		`CHK("base", 32'h12345000, result)
		`CHK("internal", 0, q_addr.size())
		fc = 4'h5;
		cdata = 32'h0ABCD000;
		issue(RMW_KIND_MBAR_WR);
		wait_done();
		`CHK("base_refused", 1'b1, stk[4])
		fc = 4'h7;
		issue(RMW_KIND_MBAR_RD);
		wait_done();
		`CHK("base_kept", 32'h12345000, result)
		for (int i = 0; i < 4; i++) begin
			tick(1);
			probe = pr[i];
			tick(1);
			@(negedge clk);
			`CHK("hit", i < 2, hit)
		end
	endtask
	task test_done;
		$display("errors %0d tests %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		tick(6);
		rst = 0;
		t_rmw1();
		t_rmw2();
		t_rmw_skip();
		t_swbp();
		t_hw_bgnd();
		t_hwbp(1'b0);
		t_hwbp(1'b1);
		t_lps();
		t_mbar();
		test_done();
	end
	initial begin
		#500000;
		err_count++;
		test_done();
	end
endmodule
